// ===== logic/arf_fifo_readback.sv
// Result FIFO with serial readback, ready indication, status flags and CRC.
//
// Overview of operation
// [RULE1] Readback lasts 16 command clocks plus samples times sample length.
// [RULE2] A sample takes 16 clocks without tag byte, 24 with it.
// [RULE3] Converter cannot write the FIFO while the link reads it.
// [RULE4] Data-out pin shows ready: high while writing, low when readable.
// [RULE5] Watermark mode: ready stays busy until count reaches the watermark.
// [RULE6] Streaming mode: ready pulses busy on every result write.
// [RULE7] Tag: channel bits 3..0, empty 4, watermark 5, limit 6, bit 7 reserved.
// [RULE8] Tag stored with every result; clearing tag-append removes it. The code stores a zero tag byte while tag-append is off.
// [RULE9] The tag of the last sample read carries the empty bit.
// [RULE10] Watermark flag follows count at or above watermark; tags carry it.
// [RULE11] Tag limit bit set per sample when enabled and result beyond limits.
// [RULE12] Status append sends the flags during the sample-count byte.
// [RULE13] Empty sets on last sample read or empty read; clears on write.
// [RULE14] Overrun sets on any lost result; clears on full readout or clear.
// [RULE15] Upper and lower limit flags are sticky until full readout or clear.
// [RULE16] Read during a write sets read error and returns zero bytes.
// [RULE17] A write waits at most one conversion; then it drops with write error.
// [RULE18] Watermark mode write at count equal to watermark sets write error.
// [RULE19] Controller error bit mirrors the general status controller error.
// [RULE20] CRC only with status append off, tag on, and CRC enabled.
// [RULE21] CRC follows each watermark block; first one covers command and count.
// [RULE22] CRC polynomial 0xa2eb, seeded with all ones.
// [RULE23] Host sends command 0x7d then a count byte, zero meaning 256.
// [RULE24] Readback ends on chip select high or after the requested samples.
`timescale 1ns/1ns
`default_nettype none

module arf_fifo_readback
  import arf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NUM_INPUTS = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Serial link pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic dout_rdy,
  // Converter results.
  input wire logic conv_valid,
  input wire arf_pkg::arf_result_t conv_result,
  // Configuration.
  input wire arf_pkg::arf_cfg_t cfg,
  input wire logic [NUM_INPUTS-1:0] per_input_limit_enable,
  input wire logic [15:0] upper_limit_value,
  input wire logic [15:0] lower_limit_value,
  input wire logic fifo_clear,
  input wire logic controller_err,
  // Status.
  output arf_pkg::arf_flags_t fifo_flags,
  output logic [7:0] sample_tag_byte
);

  import arf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [1:0] mosi_sync;
    arf_phase_t phase;
    logic [4:0] bit_cnt;
    logic [7:0] cmd_sr;
    logic [8:0] n_req;
    logic [8:0] n_done;
    logic [8:0] blk_cnt;
    logic crc_unit;
    logic crc_load;
    logic serve_zero;
    logic [23:0] tx;
    logic miso;
    logic [ADDR_W-1:0] wr_ptr;
    logic [ADDR_W-1:0] rd_ptr;
    logic [8:0] count;
    logic pend;
    arf_result_t pend_res;
    logic [3:0] busy_cnt;
    arf_flags_t flags;
    logic [7:0] tag;
    logic dout;
  } arf_state_t;

  arf_state_t s_q;
  arf_state_t s_d;

  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [23:0] mem_wdata;
  logic [23:0] mem_rdata;
  logic crc_init;
  logic crc_en;
  logic crc_bit;
  logic [15:0] crc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    logic rise;
    logic fall;
    logic cs_low;
    logic in_read;
    logic do_write;
    logic load;
    logic crc_act;
    logic [8:0] wm_eff;
    logic [4:0] unit_len;
    arf_result_t wres;
    logic [7:0] wtag;
    logic limit_hi;
    logic limit_lo;
    rise = 1'b0;
    fall = 1'b0;
    cs_low = 1'b0;
    in_read = 1'b0;
    do_write = 1'b0;
    load = 1'b0;
    crc_act = 1'b0;
    wm_eff = 9'h000;
    unit_len = 5'h00;
    wres = '0;
    wtag = 8'h00;
    limit_hi = 1'b0;
    limit_lo = 1'b0;
    s_d = s_q;
    mem_we = 1'b0;
    mem_waddr = s_q.wr_ptr;
    mem_wdata = 24'h000000;
    crc_init = 1'b0;
    crc_en = 1'b0;
    crc_bit = 1'b0;

    // Pins pass two flip-flops; edges compare the second and third stage.
    s_d.cs_sync = {s_q.cs_sync[1:0], cs_n};
    s_d.sclk_sync = {s_q.sclk_sync[1:0], sclk};
    s_d.mosi_sync = {s_q.mosi_sync[0], mosi};
    rise = s_q.sclk_sync[1] & ~s_q.sclk_sync[2];
    fall = ~s_q.sclk_sync[1] & s_q.sclk_sync[2];
    cs_low = ~s_q.cs_sync[1];

    wm_eff = (cfg.watermark == 8'h00) ? ARF_FULL_COUNT : {1'b0, cfg.watermark};
    crc_act = cfg.crc_enable & cfg.tag_append & ~cfg.status_append; // [RULE20]
    in_read = (s_q.phase == ARF_DATA);
    s_d.flags.controller_err = controller_err; // [RULE19]
    if (s_q.busy_cnt != 4'h0)
    begin
      s_d.busy_cnt = s_q.busy_cnt - 4'h1;
    end

    // Clear first so that a hardware set in the same cycle wins.
    if (fifo_clear)
    begin
      s_d.wr_ptr = '0;
      s_d.rd_ptr = '0;
      s_d.count = 9'h000;
      s_d.flags.empty = 1'b1;
      s_d.flags.overrun = 1'b0; // [RULE14]
      s_d.flags.write_err = 1'b0; // [RULE18]
      s_d.flags.upper_limit_sticky = 1'b0; // [RULE15]
      s_d.flags.lower_limit_sticky = 1'b0;
    end

    // Converter side. One result may wait out a readback; a second is lost.
    if (in_read)
    begin
      if (conv_valid)
      begin
        if (s_q.pend)
        begin
          s_d.flags.write_err = 1'b1; // [RULE17]
          s_d.flags.overrun = 1'b1; // [RULE14]
        end
        else
        begin
          s_d.pend = 1'b1; // [RULE3]
          s_d.pend_res = conv_result;
        end
      end
    end
    else if (s_q.pend)
    begin
      do_write = 1'b1;
      wres = s_q.pend_res;
      s_d.pend = conv_valid;
      s_d.pend_res = conv_result;
    end
    else if (conv_valid)
    begin
      do_write = 1'b1;
      wres = conv_result;
    end

    if (do_write)
    begin
      if (!cfg.streaming && (s_d.count == wm_eff))
      begin
        s_d.flags.write_err = 1'b1; // [RULE18]
        s_d.flags.overrun = 1'b1; // [RULE14]
      end
      else
      begin
        if (cfg.streaming && (s_d.count == ARF_FULL_COUNT))
        begin
          s_d.rd_ptr = s_d.rd_ptr + 1'b1;
          s_d.flags.overrun = 1'b1; // [RULE14]
        end
        else
        begin
          s_d.count = s_d.count + 9'h001;
        end
        limit_hi = per_input_limit_enable[wres.channel] && (wres.data > upper_limit_value); // [RULE11]
        limit_lo = per_input_limit_enable[wres.channel] && (wres.data < lower_limit_value);
        wtag = 8'h00;
        wtag[ARF_TAG_CH_LSB +: 4] = wres.channel; // [RULE7]
        wtag[ARF_TAG_WM_BIT] = (s_d.count >= wm_eff); // [RULE10]
        wtag[ARF_TAG_LIMIT_BIT] = limit_hi | limit_lo; // [RULE11]
        mem_we = 1'b1;
        mem_waddr = s_d.wr_ptr;
        mem_wdata = {wres.data, cfg.tag_append ? wtag : 8'h00}; // [RULE8]
        s_d.wr_ptr = s_d.wr_ptr + 1'b1;
        s_d.flags.upper_limit_sticky = s_d.flags.upper_limit_sticky | limit_hi; // [RULE15]
        s_d.flags.lower_limit_sticky = s_d.flags.lower_limit_sticky | limit_lo;
        s_d.flags.empty = 1'b0; // [RULE13]
        s_d.busy_cnt = 4'(ARF_BUSY_CYC); // [RULE6]
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side.

    unit_len = s_q.crc_unit ? 5'(ARF_CRC_LEN)
             : (cfg.tag_append ? 5'(ARF_SAMPLE_LEN_TAG) : 5'(ARF_SAMPLE_LEN_NOTAG)); // [RULE2]
    unique case (s_q.phase)
      ARF_IDLE:
      begin
        if (cs_low)
        begin
          s_d.phase = ARF_CMD;
          s_d.bit_cnt = 5'h00;
          s_d.tx = 24'h000000;
          s_d.crc_unit = 1'b0;
          s_d.crc_load = 1'b0;
          // The refusal is judged when the host starts, while a write is still visible.
          s_d.serve_zero = (s_q.busy_cnt != 4'h0); // [RULE16]
          crc_init = 1'b1; // [RULE22]
        end
      end
      ARF_CMD:
      begin
        if (rise)
        begin
          s_d.cmd_sr = {s_q.cmd_sr[6:0], s_q.mosi_sync[1]};
          crc_en = 1'b1; // [RULE21]
          crc_bit = s_q.mosi_sync[1];
          s_d.bit_cnt = s_q.bit_cnt + 5'h01;
          if (s_q.bit_cnt == 5'd7)
          begin
            if (s_d.cmd_sr != ARF_CMD_FIFO_READ)
            begin
              s_d.phase = ARF_DONE; // [RULE23]
            end
            else if (cfg.status_append)
            begin
              s_d.tx = {s_q.flags, 16'h0000}; // [RULE12]
            end
          end
          if (s_q.bit_cnt == 5'(ARF_CMD_LEN - 1))
          begin
            s_d.n_req = (s_d.cmd_sr == 8'h00) ? ARF_FULL_COUNT : {1'b0, s_d.cmd_sr}; // [RULE23]
            s_d.n_done = 9'h000;
            s_d.blk_cnt = 9'h000;
            s_d.bit_cnt = 5'h00;
            s_d.phase = ARF_DATA; // [RULE1]
            s_d.flags.read_err = s_q.serve_zero; // [RULE16]
            load = 1'b1;
          end
        end
      end
      ARF_DATA:
      begin
        if (s_q.crc_load)
        begin
          // CRC is taken one cycle after the block so that its last bit is in.
          s_d.crc_load = 1'b0;
          s_d.tx = {crc_q, 8'h00}; // [RULE21]
        end
        if (rise)
        begin
          crc_en = 1'b1;
          crc_bit = s_q.miso;
          s_d.bit_cnt = s_q.bit_cnt + 5'h01;
          if (s_q.bit_cnt == unit_len - 5'h01)
          begin
            s_d.bit_cnt = 5'h00;
            if (s_q.crc_unit)
            begin
              crc_en = 1'b0;
              crc_init = 1'b1; // [RULE21]
              s_d.crc_unit = 1'b0;
              if (s_q.n_done == s_q.n_req)
              begin
                s_d.phase = ARF_DONE;
              end
              else
              begin
                load = 1'b1;
              end
            end
            else
            begin
              s_d.n_done = s_q.n_done + 9'h001;
              s_d.blk_cnt = s_q.blk_cnt + 9'h001;
              if (crc_act && (s_d.blk_cnt == wm_eff))
              begin
                s_d.blk_cnt = 9'h000;
                s_d.crc_unit = 1'b1;
                s_d.crc_load = 1'b1;
              end
              else if (s_d.n_done == s_q.n_req)
              begin
                s_d.phase = ARF_DONE; // [RULE24]
              end
              else
              begin
                load = 1'b1;
              end
            end
          end
        end
      end
      ARF_DONE:
      begin
      end
    endcase

    // Fetching a sample pops the FIFO just before its first bit leaves.
    if (load)
    begin
      s_d.tx = 24'h000000;
      s_d.tag = 8'h00;
      if (s_d.serve_zero)
      begin
        s_d.tx = 24'h000000; // [RULE16]
      end
      else if (s_d.count == 9'h000)
      begin
        s_d.flags.empty = 1'b1; // [RULE13]
      end
      else
      begin
        s_d.tag = mem_rdata[7:0];
        s_d.tag[ARF_TAG_EMPTY_BIT] = cfg.tag_append && (s_d.count == 9'h001); // [RULE9]
        s_d.tx = cfg.tag_append ? {mem_rdata[23:8], s_d.tag} : {mem_rdata[23:8], 8'h00}; // [RULE8]
        s_d.rd_ptr = s_d.rd_ptr + 1'b1;
        s_d.count = s_d.count - 9'h001;
        if (s_d.count == 9'h000)
        begin
          // A full readout clears the error and sticky flags.
          s_d.flags.empty = 1'b1; // [RULE13]
          s_d.flags.overrun = 1'b0; // [RULE14]
          s_d.flags.write_err = 1'b0; // [RULE18]
          s_d.flags.read_err = 1'b0; // [RULE16]
          s_d.flags.upper_limit_sticky = 1'b0; // [RULE15]
          s_d.flags.lower_limit_sticky = 1'b0;
        end
      end
    end

    if ((s_q.phase == ARF_CMD || s_q.phase == ARF_DATA) && fall)
    begin
      s_d.miso = s_d.tx[23];
      s_d.tx = {s_d.tx[22:0], 1'b0};
    end

    // Chip select high ends any transfer at once.
    if (!cs_low)
    begin
      s_d.phase = ARF_IDLE; // [RULE24]
      s_d.miso = 1'b0;
    end

    s_d.flags.watermark = (s_d.count >= wm_eff); // [RULE10]

    // Outside a transfer the pin shows readiness rather than data.
    if (s_d.phase == ARF_CMD || s_d.phase == ARF_DATA)
    begin
      s_d.dout = s_d.miso;
    end
    else if (cfg.streaming)
    begin
      s_d.dout = (s_d.busy_cnt != 4'h0); // [RULE6]
    end
    else
    begin
      s_d.dout = (s_d.busy_cnt != 4'h0) || (s_d.count < wm_eff); // [RULE4] [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.cs_sync <= 3'h7;
      s_q.sclk_sync <= 3'h7;
      s_q.phase <= ARF_IDLE;
      s_q.flags <= ARF_FIFO_FLAGS_RESET;
      s_q.tag <= ARF_SAMPLE_TAG_RESET;
      s_q.dout <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout_rdy = s_q.dout;
  assign fifo_flags = s_q.flags;
  assign sample_tag_byte = s_q.tag;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and CRC.

  arf_mem #(
    .WIDTH(24),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clock(clock),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(s_q.rd_ptr),
    .rdata(mem_rdata)
  );

  arf_crc u_crc (
    .clock(clock),
    .nrst(nrst),
    .init(crc_init),
    .en(crc_en),
    .bit_in(crc_bit),
    .crc_q(crc_q)
  );

endmodule
`default_nettype wire

// ===== logic/arf_pkg.sv
// Shared constants and types for the result FIFO readback block.
package arf_pkg;

  // Readback protocol.
  localparam logic [7:0] ARF_CMD_FIFO_READ = 8'h7d;
  localparam int ARF_CMD_LEN = 16;
  localparam int ARF_SAMPLE_LEN_TAG = 24;
  localparam int ARF_SAMPLE_LEN_NOTAG = 16;
  localparam int ARF_CRC_LEN = 16;
  localparam logic [8:0] ARF_FULL_COUNT = 9'h100;

  // Register map; the tag byte has no address of its own.
  localparam logic [7:0] ARF_FIFO_FLAGS_ADDR = 8'h3b;
  localparam logic [7:0] ARF_FIFO_FLAGS_RESET = 8'h01;
  localparam logic [7:0] ARF_SAMPLE_TAG_RESET = 8'h00;

  // Tag byte field positions.
  localparam int ARF_TAG_CH_LSB = 0;
  localparam int ARF_TAG_EMPTY_BIT = 4;
  localparam int ARF_TAG_WM_BIT = 5;
  localparam int ARF_TAG_LIMIT_BIT = 6;

  // CRC.
  localparam logic [15:0] ARF_CRC_POLY = 16'ha2eb;
  localparam logic [15:0] ARF_CRC_SEED = 16'hffff;

  // Timing: the busy window that follows each result write.
  localparam int ARF_CLK_NS = 50;
  localparam int ARF_BUSY_NS = 400;
  localparam int ARF_BUSY_CYC = (ARF_BUSY_NS + ARF_CLK_NS - 1) / ARF_CLK_NS;

  typedef enum logic [1:0] {ARF_IDLE, ARF_CMD, ARF_DATA, ARF_DONE} arf_phase_t;

  typedef struct packed {
    logic [3:0] channel;
    logic [15:0] data;
  } arf_result_t;

  typedef struct packed {
    logic tag_append;
    logic status_append;
    logic crc_enable;
    logic streaming;
    logic [7:0] watermark;
  } arf_cfg_t;

  typedef struct packed {
    logic controller_err;
    logic write_err;
    logic read_err;
    logic upper_limit_sticky;
    logic lower_limit_sticky;
    logic overrun;
    logic watermark;
    logic empty;
  } arf_flags_t;

endpackage

// ===== logic/arf_mem.sv
// Sample storage with a registered read port.
`timescale 1ns/1ns
`default_nettype none

module arf_mem #(
  parameter int WIDTH = 24,
  parameter int ADDR_W = 8
) (
  // Clock.
  input wire logic clock,
  // Write port.
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port.
  input wire logic [ADDR_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// ===== logic/arf_crc.sv
// Serial CRC-16 over the bits seen on the link.
`timescale 1ns/1ns
`default_nettype none

module arf_crc
  import arf_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Control.
  input wire logic init,
  input wire logic en,
  input wire logic bit_in,
  // Result.
  output logic [15:0] crc_q
);

  logic [15:0] crc_d;
  logic fb;

  always_comb
  begin
    fb = bit_in ^ crc_q[15];
    crc_d = crc_q;
    if (init)
    begin
      crc_d = ARF_CRC_SEED; // [RULE22]
    end
    else if (en)
    begin
      crc_d = {crc_q[14:0], 1'b0} ^ (fb ? ARF_CRC_POLY : 16'h0000); // [RULE22]
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      crc_q <= ARF_CRC_SEED;
    end
    else
    begin
      crc_q <= crc_d;
    end
  end

endmodule
`default_nettype wire

// ===== verif/arf_fifo_chk.sv
// Concurrent checks on the result FIFO readback ports.
`timescale 1ns/1ns
`default_nettype none

module arf_fifo_chk
  import arf_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Link and converter.
  input wire logic cs_n,
  input wire logic dout_rdy,
  input wire logic conv_valid,
  input wire arf_pkg::arf_cfg_t cfg,
  input wire logic fifo_clear,
  input wire logic controller_err,
  // Status.
  input wire arf_pkg::arf_flags_t fifo_flags,
  input wire logic [7:0] sample_tag_byte
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////
  // The pin may still carry a data bit for a few clocks after chip select moves.
  logic [3:0] cs_hist_q;
  logic idle;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      cs_hist_q <= 4'hf;
    else
      cs_hist_q <= {cs_hist_q[2:0], cs_n};
  assign idle = cs_n && (cs_hist_q == 4'hf);

  sequence busy_seq;
    ##2 (dout_rdy || !cs_n) [*6];
  endsequence

  ////////////////////////////////////////
  ctrl_err_mirror_a: assert property ($past(nrst) |-> fifo_flags.controller_err == $past(controller_err))
    else $error("controller error bit does not follow its input");
  write_clears_empty_a: assert property (conv_valid && idle && !fifo_clear |=> !fifo_flags.empty)
    else $error("empty flag stayed set after a write");
  clear_flags_a: assert property (fifo_clear && !conv_valid |=> fifo_flags.empty && !fifo_flags.overrun
    && !fifo_flags.write_err && !fifo_flags.upper_limit_sticky && !fifo_flags.lower_limit_sticky)
    else $error("clear left a flag in the wrong state");
  full_write_err_a: assert property (conv_valid && !cfg.streaming && fifo_flags.watermark && idle
    && !fifo_clear |=> fifo_flags.write_err && fifo_flags.overrun)
    else $error("write at the watermark raised no error");
  stream_busy_a: assert property (conv_valid && cfg.streaming |-> busy_seq)
    else $error("no busy pulse after a streaming write");
  wm_ready_a: assert property (!cfg.streaming && idle && !fifo_flags.watermark |-> dout_rdy)
    else $error("ready shown below the watermark");
  wm_fall_a: assert property ($fell(fifo_flags.watermark) |-> !$past(cs_n) || $past(fifo_clear))
    else $error("watermark flag dropped without a read");
  sticky_hold_a: assert property ($fell(fifo_flags.upper_limit_sticky) || $fell(fifo_flags.lower_limit_sticky)
    |-> !$past(cs_n) || $past(fifo_clear))
    else $error("limit flag dropped without readout");
  err_read_zero_a: assert property (fifo_flags.read_err && !cs_n && cs_hist_q == 4'h0 |-> !dout_rdy)
    else $error("refused read sent a one");
  tag_reserved_a: assert property (sample_tag_byte[7] == 1'b0)
    else $error("reserved tag bit set");
endmodule

bind arf_fifo_readback arf_fifo_chk chk (.clock(clock), .nrst(nrst), .cs_n(cs_n), .dout_rdy(dout_rdy),
  .conv_valid(conv_valid), .cfg(cfg), .fifo_clear(fifo_clear), .controller_err(controller_err),
  .fifo_flags(fifo_flags), .sample_tag_byte(sample_tag_byte));

`default_nettype wire

// ===== verif/arf_host_model.sv
// Behavioural host controller for the FIFO readback link.
`timescale 1ns/1ns
`default_nettype none

module arf_host_model (
  // Link pins.
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic dout_rdy
);
  logic rx_q[$];

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b1;
  end

  ////////////////////////////////////////
  // Clock idles high between frames; after the header the data line toggles, as a released wire holds no value.
  task automatic xfer(input logic [7:0] num, input int nbits, input int half);
    logic [15:0] hdr;
    hdr = {8'h7d, num};
    rx_q.delete();
    cs_n = 1'b0;
    #(half);
    for (int i = 0; i < nbits; i++)
    begin
      sclk = 1'b0;
      mosi = (i < 16) ? hdr[15 - i] : ~mosi;
      #(half);
      sclk = 1'b1;
      rx_q.push_back(dout_rdy);
      #(half);
    end
    cs_n = 1'b1;
    mosi = ~mosi;
    #(2 * half);
  endtask
endmodule

`default_nettype wire

// ===== verif/test_adc_result_fifo_readback.sv
// Self-checking bench for the result FIFO readback block.
`timescale 1ns/1ns
`default_nettype none

module test_adc_result_fifo_readback;
  import arf_pkg::*;
  logic clock, nrst, cs_n, sclk, mosi, dout_rdy, conv_valid, fifo_clear, controller_err;
  logic [15:0] lim_en, upper_limit_value, lower_limit_value, lfsr;
  logic [7:0] sample_tag_byte, last_tag;
  logic [23:0] exp_q[$];
  arf_result_t conv_result;
  arf_cfg_t cfg;
  arf_flags_t fifo_flags;
  int n_fail, n_tests;

  arf_fifo_readback dut (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .dout_rdy(dout_rdy),
    .conv_valid(conv_valid), .conv_result(conv_result), .cfg(cfg), .per_input_limit_enable(lim_en),
    .upper_limit_value(upper_limit_value), .lower_limit_value(lower_limit_value), .fifo_clear(fifo_clear),
    .controller_err(controller_err), .fifo_flags(fifo_flags), .sample_tag_byte(sample_tag_byte));
  arf_host_model host (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .dout_rdy(dout_rdy));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'ha2eb : 16'h0000);
  endfunction

  function automatic logic [23:0] take(input int k);
    logic [23:0] v;
    v = 24'h0;
    for (int i = 0; i < k; i++)
      v = {v[22:0], host.rx_q.pop_front()};
    return v;
  endfunction

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // The model holds only what should be stored; dropped results show in the caller's flag figures.
  task automatic put(input logic [3:0] ch, input logic [15:0] d);
    int wme;
    wme = (cfg.watermark == 8'h00) ? 256 : int'(cfg.watermark);
    if (cfg.streaming || exp_q.size() < wme)
      exp_q.push_back({d, 1'b0, lim_en[ch] && (d > upper_limit_value || d < lower_limit_value),
        exp_q.size() + 1 >= wme, 1'b0, ch});
    conv_result = '{channel: ch, data: d};
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
    tick(1);
  endtask

  task automatic rd(input int n, input logic zero, input logic [7:0] stat, input int half);
    int len, nb;
    logic [23:0] e;
    logic [15:0] crc, hdr;
    len = cfg.tag_append ? 24 : 16;
    nb = 16 + n * len;
    if (cfg.crc_enable && cfg.tag_append && !cfg.status_append)
      nb = nb + 16;
    hdr = {8'h7d, n[7:0]};
    crc = 16'hffff;
    for (int i = 15; i >= 0; i--)
      crc = crc_bit(crc, hdr[i]);
    host.xfer(n[7:0], nb, half);
    check(24'(host.rx_q.size()), 24'(nb));
    check(take(16), {16'h0, stat});
    for (int s = 0; s < n; s++)
    begin
      e = zero ? 24'h0 : exp_q.pop_front();
      if (!zero && exp_q.size() == 0)
        e[4] = 1'b1;
      last_tag = e[7:0];
      if (len == 16)
        e = {8'h00, e[23:8]};
      check(take(len), e);
      for (int i = len - 1; i >= 0; i--)
        crc = crc_bit(crc, e[i]);
    end
    if (nb > 16 + n * len)
      check(take(16), {8'h00, crc});
    tick(4);
  endtask

  ////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    conv_valid = 1'b0;
    conv_result = '0;
    fifo_clear = 1'b0;
    controller_err = 1'b0;
    cfg = '{tag_append: 1'b1, status_append: 1'b0, crc_enable: 1'b0, streaming: 1'b0, watermark: 8'h03};
    lim_en = 16'h00ff;
    upper_limit_value = 16'hc000;
    lower_limit_value = 16'h2000;
    lfsr = 16'h74c2;
    last_tag = 8'h00;
    n_fail = 0;
    n_tests = 0;
    tick(6);
    nrst = 1'b1;
    tick(3);
    check(24'(fifo_flags), 24'h01);
    check(24'(sample_tag_byte), 24'h00);
    check(24'(dout_rdy), 24'h1);
    $display("reset test done");
    put(4'h1, 16'hf000);
    tick(10);
    check(24'(dout_rdy), 24'h1);
    put(4'h2, 16'h1000);
    lfsr = lfsr_next(lfsr);
    put({1'b0, lfsr[2:0]}, {4'h4, lfsr[15:4]});
    tick(10);
    check(24'(fifo_flags), 24'h1a);
    check(24'(dout_rdy), 24'h0);
    put(4'h3, 16'h5555);
    tick(10);
    check(24'(fifo_flags), 24'h5e);
    rd(3, 1'b0, 8'h00, 200);
    check(24'(fifo_flags), 24'h01);
    check(24'(sample_tag_byte), 24'(last_tag));
    $display("watermark test done");
    cfg.watermark = 8'h01;
    tick(2);
    put(4'h4, 16'h3000);
    rd(1, 1'b1, 8'h00, 200);
    check(24'(fifo_flags), 24'h22);
    rd(1, 1'b0, 8'h00, 200);
    check(24'(fifo_flags), 24'h01);
    $display("read error test done");
    fifo_clear = 1'b1;
    tick(1);
    fifo_clear = 1'b0;
    cfg = '{tag_append: 1'b1, status_append: 1'b0, crc_enable: 1'b1, streaming: 1'b1, watermark: 8'h02};
    tick(2);
    for (int i = 0; i < 2; i++)
    begin
      lfsr = lfsr_next(lfsr);
      put({1'b0, lfsr[2:0]}, {4'h6, lfsr[15:4]});
      check(24'(dout_rdy), 24'h1);
      tick(10);
      check(24'(dout_rdy), 24'h0);
    end
    rd(2, 1'b0, 8'h00, 200);
    check(24'(fifo_flags), 24'h01);
    $display("streaming crc test done");
    cfg = '{tag_append: 1'b0, status_append: 1'b1, crc_enable: 1'b1, streaming: 1'b1, watermark: 8'h02};
    controller_err = 1'b1;
    lfsr = lfsr_next(lfsr);
    put(lfsr[3:0], {4'h7, lfsr[11:0]});
    tick(10);
    rd(1, 1'b0, 8'h80, 300);
    check(24'(fifo_flags), 24'h81);
    controller_err = 1'b0;
    tick(2);
    check(24'(fifo_flags), 24'h01);
    $display("status append test done");
    test_done();
  end

  // The whole sequence needs about 125 us; four times that means a hang.
  initial
  begin
    #500000;
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire
